// File: src/rtcs_pkg.sv
/*
 Shared constants and types for the two-wire clock/RAM slave.
 Assumes a single core clock and a free-running link sampling clock.
*/
package rtcs_pkg;
   // Seven-bit slave address; the address byte with write direction is D0h
   localparam logic [6:0] SLAVE_ADDR = 7'h68;
   localparam int MEM_DEPTH = 64;
   localparam int ADDR_W = 6;
   localparam int CLOCK_BYTES = 8;
   localparam int FILT_LEN = 3;
   localparam logic [ADDR_W-1:0] PTR_RST = 6'h00;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [3:0] BCD_MAX = 4'h9;
   localparam logic [7:0] MEM_RST = 8'h00;
   localparam logic SCL_RST = 1'b1;
   localparam logic SDA_RST = 1'b1;
   localparam logic PF_RST = 1'b0;

   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_WAIT} rtcs_state_t;
   typedef enum logic [1:0] {PH_SADDR, PH_WADDR, PH_DATA} rtcs_phase_t;
endpackage

// File: src/rtcs_in_filt.sv
/*
 Input synchroniser with glitch filter.
 Assumes din is asynchronous to clk; dout moves only after LEN equal samples.
*/
`timescale 1ns/1ps
module rtcs_in_filt
   import rtcs_pkg::*;
#(
   parameter int LEN = FILT_LEN,
   parameter logic RST_VAL = 1'b1
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic din,
   output logic dout
);
   generate
      if (LEN < 1)
      begin : g_chk
         $error("Filter length must be at least one");
      end
   endgenerate

   logic sync1_r;
   logic sync2_r;
   logic [LEN-1:0] hist_r;
   logic [LEN-1:0] hist_nxt;
   logic dout_nxt;

   always_comb
   begin
      hist_nxt = LEN'({hist_r, sync2_r});
      dout_nxt = dout;
      if (&hist_r)
         dout_nxt = 1'b1;
      else if (~|hist_r)
         dout_nxt = 1'b0;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         sync1_r <= RST_VAL;
         sync2_r <= RST_VAL;
         hist_r <= {LEN{RST_VAL}};
         dout <= RST_VAL;
      end
      else
      begin
         sync1_r <= din;
         sync2_r <= sync1_r;
         hist_r <= hist_nxt;
         dout <= dout_nxt;
      end
   end
endmodule

// File: src/rtcs_req_xfer.sv
/*
 Toggle handshake carrying one memory request from the link domain to the
 core domain and the read byte back. Assumes one request at a time.
*/
`timescale 1ns/1ps
module rtcs_req_xfer
   import rtcs_pkg::*;
(
   input wire logic src_clk,
   input wire logic dst_clk,
   input wire logic reset,
   input wire logic src_go,
   input wire logic src_we,
   input wire logic [ADDR_W-1:0] src_addr,
   input wire logic [7:0] src_wdata,
   output logic src_done,
   output logic [7:0] src_rdata,
   output logic dst_req,
   output logic dst_we,
   output logic [ADDR_W-1:0] dst_addr,
   output logic [7:0] dst_wdata,
   input wire logic [7:0] dst_rdata
);
   logic req_t;
   logic ack_t;
   logic [2:0] rs_r;
   logic [2:0] as_r;
   logic [7:0] rdata_r;

   // Request word held steady from the toggle until the next request
   always_ff @(posedge src_clk or posedge reset)
   begin
      if (reset)
      begin
         req_t <= 1'b0;
         dst_we <= 1'b0;
         dst_addr <= PTR_RST;
         dst_wdata <= MEM_RST;
         as_r <= 3'h0;
      end
      else
      begin
         as_r <= {as_r[1:0], ack_t};
         if (src_go)
         begin
            req_t <= ~req_t;
            dst_we <= src_we;
            dst_addr <= src_addr;
            dst_wdata <= src_wdata;
         end
      end
   end

   always_ff @(posedge dst_clk or posedge reset)
   begin
      if (reset)
      begin
         rs_r <= 3'h0;
         ack_t <= 1'b0;
         rdata_r <= MEM_RST;
      end
      else
      begin
         rs_r <= {rs_r[1:0], req_t};
         if (dst_req)
         begin
            ack_t <= ~ack_t;
            rdata_r <= dst_rdata;
         end
      end
   end

   assign dst_req = rs_r[2] ^ rs_r[1];
   assign src_done = as_r[2] ^ as_r[1];
   assign src_rdata = rdata_r;
endmodule

// File: src/rtcs_top.sv
/*
 Two-wire slave of a clock/calendar with battery-backed RAM: bus front end
 on link_clk, 64-byte store on core_clk.
 Assumes link_clk runs free and much faster than the bus clock.
*/
// Operation
// - Answer only the fixed slave address following a START.
// - Sixty-four locations: seven time bytes, control, then RAM.
// - First eight locations hold clock/calendar values in BCD.
// - Remaining locations are RAM reading back the last written value.
// - Pointer steps by one after each data byte written, or read and acknowledged.
// - Power fail aborts any access and clears the pointer.
// - While power fail holds, all bus inputs are ignored.
// - Data held while clock high; changes then are bus conditions.
// - START is data falling while clock is high.
// - STOP is data rising while clock is high; ends transfer.
// - One clock pulse per bit; data changes only while clock low.
// - Transfers open with START, close with STOP, any byte count.
// - Eight-bit bytes, MSB first, acknowledged in a ninth slot.
// - On reads the pointer advances only on master acknowledge.
// - Word address write then repeated START with read direction.
// - Master nack ends a read; slave releases data line.
// - Acknowledge all written bytes; bare read starts at stored pointer.
`timescale 1ns/1ps
module rtcs_top
   import rtcs_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic link_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic power_fail_trip_level,
   input wire logic upd_valid,
   input wire logic [2:0] upd_addr,
   input wire logic [7:0] upd_data,
   output logic bus_active
);
   logic scl_f;
   logic sda_f;
   logic pf_s;
   logic scl_p_r;
   logic sda_p_r;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   rtcs_state_t state_r;
   rtcs_state_t state_nxt;
   rtcs_phase_t phase_r;
   rtcs_phase_t phase_nxt;
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic [7:0] rx_r;
   logic [7:0] rx_nxt;
   logic [7:0] tx_r;
   logic [7:0] tx_nxt;
   logic [ADDR_W-1:0] ptr_r;
   logic [ADDR_W-1:0] ptr_nxt;
   logic rw_r;
   logic rw_nxt;
   logic mack_r;
   logic mack_nxt;
   logic oe_r;
   logic oe_nxt;
   logic act_r;
   logic go;
   logic go_we;
   logic [ADDR_W-1:0] go_addr;
   logic rd_done;
   logic [7:0] rd_data;

   logic x_req;
   logic x_we;
   logic [ADDR_W-1:0] x_addr;
   logic [7:0] x_wdata;
   logic [7:0] x_rdata;
   logic [7:0] mem_r [MEM_DEPTH];
   logic [7:0] mem_nxt [MEM_DEPTH];

   // Keeps the control bits in the high nibble, clamps the digit
   function automatic logic [7:0] bcd_fix(input logic [7:0] d);
      bcd_fix = {d[7:4], (d[3:0] > BCD_MAX) ? BCD_MAX : d[3:0]};
   endfunction

   // Line conditioning
   rtcs_in_filt #(.LEN(FILT_LEN), .RST_VAL(SCL_RST)) u_scl (
      .clk(link_clk),
      .reset(reset),
      .din(scl_in),
      .dout(scl_f)
   );
   rtcs_in_filt #(.LEN(FILT_LEN), .RST_VAL(SDA_RST)) u_sda (
      .clk(link_clk),
      .reset(reset),
      .din(sda_in),
      .dout(sda_f)
   );
   rtcs_in_filt #(.LEN(1), .RST_VAL(PF_RST)) u_pf (
      .clk(link_clk),
      .reset(reset),
      .din(power_fail_trip_level),
      .dout(pf_s)
   );

   assign scl_rise = scl_f & ~scl_p_r;
   assign scl_fall = ~scl_f & scl_p_r;
   assign start_det = scl_f & scl_p_r & sda_p_r & ~sda_f;
   assign stop_det = scl_f & scl_p_r & ~sda_p_r & sda_f;

   // Bus protocol engine
   always_comb
   begin
      state_nxt = state_r;
      phase_nxt = phase_r;
      cnt_nxt = cnt_r;
      rx_nxt = rx_r;
      tx_nxt = tx_r;
      ptr_nxt = ptr_r;
      rw_nxt = rw_r;
      mack_nxt = mack_r;
      oe_nxt = oe_r;
      go = 1'b0;
      go_we = 1'b0;
      go_addr = ptr_r;
      if (rd_done)
         tx_nxt = rd_data;
      if (pf_s)
      begin
         state_nxt = ST_IDLE;
         ptr_nxt = PTR_RST;
         oe_nxt = 1'b0;
      end
      else if (stop_det)
      begin
         state_nxt = ST_IDLE;
         oe_nxt = 1'b0;
      end
      else if (start_det)
      begin
         state_nxt = ST_RX;
         phase_nxt = PH_SADDR;
         cnt_nxt = 4'h0;
         oe_nxt = 1'b0;
      end
      else
      begin
         unique case (state_r)
            ST_IDLE, ST_WAIT:
            begin
            end
            ST_RX:
            begin
               if (scl_rise && cnt_r != BYTE_BITS)
               begin
                  rx_nxt = {rx_r[6:0], sda_f};
                  cnt_nxt = cnt_r + 4'h1;
               end
               else if (scl_fall && cnt_r == BYTE_BITS)
               begin
                  cnt_nxt = 4'h0;
                  unique case (phase_r)
                     PH_SADDR:
                     begin
                        if (rx_r[7:1] == SLAVE_ADDR)
                        begin
                           state_nxt = ST_ACK;
                           oe_nxt = 1'b1;
                           rw_nxt = rx_r[0];
                           go = rx_r[0];
                        end
                        else
                           state_nxt = ST_WAIT;
                     end
                     PH_WADDR:
                     begin
                        ptr_nxt = rx_r[ADDR_W-1:0];
                        state_nxt = ST_ACK;
                        oe_nxt = 1'b1;
                     end
                     default:
                     begin
                        go = 1'b1;
                        go_we = 1'b1;
                        ptr_nxt = ptr_r + 6'h01;
                        state_nxt = ST_ACK;
                        oe_nxt = 1'b1;
                     end
                  endcase
               end
            end
            ST_ACK:
            begin
               if (scl_fall)
               begin
                  cnt_nxt = 4'h0;
                  if (rw_r)
                  begin
                     state_nxt = ST_TX;
                     oe_nxt = ~tx_nxt[7];
                  end
                  else
                  begin
                     state_nxt = ST_RX;
                     oe_nxt = 1'b0;
                     phase_nxt = (phase_r == PH_SADDR) ? PH_WADDR : PH_DATA;
                  end
               end
            end
            ST_TX:
            begin
               if (scl_fall)
               begin
                  if (cnt_r == LAST_BIT)
                  begin
                     state_nxt = ST_MACK;
                     oe_nxt = 1'b0;
                  end
                  else
                  begin
                     tx_nxt = {tx_r[6:0], 1'b0};
                     oe_nxt = ~tx_r[6];
                     cnt_nxt = cnt_r + 4'h1;
                  end
               end
            end
            ST_MACK:
            begin
               if (scl_rise)
               begin
                  mack_nxt = ~sda_f;
                  if (~sda_f)
                  begin
                     ptr_nxt = ptr_r + 6'h01;
                     go = 1'b1;
                     go_addr = ptr_r + 6'h01;
                  end
               end
               else if (scl_fall)
               begin
                  cnt_nxt = 4'h0;
                  if (mack_r)
                  begin
                     state_nxt = ST_TX;
                     oe_nxt = ~tx_nxt[7];
                  end
                  else
                  begin
                     state_nxt = ST_WAIT;
                     oe_nxt = 1'b0;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge link_clk or posedge reset)
   begin
      if (reset)
      begin
         state_r <= ST_IDLE;
         phase_r <= PH_SADDR;
         cnt_r <= 4'h0;
         rx_r <= MEM_RST;
         tx_r <= MEM_RST;
         ptr_r <= PTR_RST;
         rw_r <= 1'b0;
         mack_r <= 1'b0;
         oe_r <= 1'b0;
         act_r <= 1'b0;
         scl_p_r <= SCL_RST;
         sda_p_r <= SDA_RST;
         sda_out <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         phase_r <= phase_nxt;
         cnt_r <= cnt_nxt;
         rx_r <= rx_nxt;
         tx_r <= tx_nxt;
         ptr_r <= ptr_nxt;
         rw_r <= rw_nxt;
         mack_r <= mack_nxt;
         oe_r <= oe_nxt;
         act_r <= (state_nxt != ST_IDLE);
         scl_p_r <= scl_f;
         sda_p_r <= sda_f;
         sda_out <= 1'b0;
      end
   end

   assign sda_oe = oe_r;
   assign bus_active = act_r;

   rtcs_req_xfer u_xfer (
      .src_clk(link_clk),
      .dst_clk(core_clk),
      .reset(reset),
      .src_go(go),
      .src_we(go_we),
      .src_addr(go_addr),
      .src_wdata(rx_r),
      .src_done(rd_done),
      .src_rdata(rd_data),
      .dst_req(x_req),
      .dst_we(x_we),
      .dst_addr(x_addr),
      .dst_wdata(x_wdata),
      .dst_rdata(x_rdata)
   );

   // Byte store, clock bytes first then RAM
   generate
      for (genvar i = 0; i < MEM_DEPTH; i++)
      begin : g_mem
         localparam logic [ADDR_W-1:0] IDX = ADDR_W'(i);
         localparam bit IS_CLK = (i < CLOCK_BYTES);
         always_comb
         begin
            mem_nxt[i] = mem_r[i];
            if (IS_CLK && upd_valid && {3'h0, upd_addr} == IDX)
               mem_nxt[i] = bcd_fix(upd_data);
            if (x_req && x_we && x_addr == IDX)
               mem_nxt[i] = IS_CLK ? bcd_fix(x_wdata) : x_wdata;
         end
         always_ff @(posedge core_clk or posedge reset)
         begin
            if (reset)
               mem_r[i] <= MEM_RST;
            else
               mem_r[i] <= mem_nxt[i];
         end
         if (IS_CLK)
         begin : g_chk
            a_bcd_digit:
            assert property (@(posedge core_clk) disable iff (reset) mem_r[i][3:0] <= BCD_MAX)
               else $error("Clock byte digit out of BCD range");
         end
      end
   endgenerate

   assign x_rdata = mem_r[x_addr];

   a_ram_write:
   assert property (@(posedge core_clk) disable iff (reset)
      x_req && x_we && x_addr >= ADDR_W'(CLOCK_BYTES) |=> mem_r[$past(x_addr)] == $past(x_wdata))
      else $error("RAM byte did not take written value");

   a_pf_abort:
   assert property (@(posedge link_clk) disable iff (reset)
      pf_s |=> (ptr_r == PTR_RST) && !oe_r && state_r == ST_IDLE)
      else $error("Power fail did not abort access");

   a_pf_mask:
   assert property (@(posedge link_clk) disable iff (reset)
      pf_s [*2] |-> !go && state_r == ST_IDLE)
      else $error("Bus activity while power fail holds");

   a_start_seen:
   assert property (@(posedge link_clk) disable iff (reset)
      start_det && !pf_s && !stop_det |=> state_r == ST_RX && phase_r == PH_SADDR && cnt_r == 4'h0)
      else $error("START not taken");

   a_stop_ends:
   assert property (@(posedge link_clk) disable iff (reset)
      stop_det && !pf_s |=> state_r == ST_IDLE && !oe_r)
      else $error("STOP did not end transfer");

   a_addr_miss:
   assert property (@(posedge link_clk) disable iff (reset)
      state_r == ST_RX && phase_r == PH_SADDR && scl_fall && cnt_r == BYTE_BITS
      && rx_r[7:1] != SLAVE_ADDR && !pf_s && !start_det && !stop_det
      |=> (state_r == ST_WAIT && !oe_r) [*2])
      else $error("Foreign address acknowledged");

   a_ack_slot:
   assert property (@(posedge link_clk) disable iff (reset)
      $rose(state_r == ST_ACK) |-> oe_r && $past(cnt_r) == BYTE_BITS)
      else $error("Acknowledge not driven after eight bits");

   a_rd_advance:
   assert property (@(posedge link_clk) disable iff (reset)
      state_r == ST_MACK && scl_rise && !pf_s && !start_det && !stop_det
      |=> ptr_r == (sda_p_r ? $past(ptr_r) : $past(ptr_r) + 6'h01))
      else $error("Read pointer step wrong");

   a_wr_advance:
   assert property (@(posedge link_clk) disable iff (reset)
      go && go_we |=> ptr_r == $past(ptr_r) + 6'h01 ##1 state_r != ST_RX)
      else $error("Write pointer step wrong");

   a_nack_release:
   assert property (@(posedge link_clk) disable iff (reset)
      state_r == ST_MACK && scl_fall && !mack_r && !pf_s && !start_det && !stop_det
      |=> !oe_r throughout (state_r == ST_WAIT) [*1])
      else $error("Line not released after master nack");

   a_sda_change:
   assert property (@(posedge link_clk) disable iff (reset)
      $changed(oe_r) && !$past(pf_s) && !$past(start_det) && !$past(stop_det) |-> $past(!scl_f))
      else $error("Data line changed with clock high");
endmodule

// File: verif/rtcs_bus_master.sv
/*
 Behavioural two-wire bus master for the clock/RAM slave.
 Assumes the pulled-up data line is resolved outside; steps on clk falling edges.
*/
`timescale 1ns/1ps
module rtcs_bus_master #(
   parameter int Q = 25
)
(
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic q;
      repeat (Q) @(negedge clk);
   endtask

   // Start from idle or repeated start from clock low
   task automatic start;
      sda_low = 1'b0;
      q;
      scl = 1'b1;
      q;
      sda_low = 1'b1;
      q;
      scl = 1'b0;
      q;
   endtask

   task automatic stop;
      sda_low = 1'b1;
      q;
      scl = 1'b1;
      q;
      sda_low = 1'b0;
      q;
   endtask

   // One clock pulse per bit, data moved only while clock low
   task automatic bit_x(input logic b, output logic s);
      sda_low = ~b;
      q;
      scl = 1'b1;
      q;
      s = sda;
      q;
      scl = 1'b0;
      q;
   endtask

   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_x(d[i], s);
      end
      bit_x(1'b1, s);
      ack = ~s;
   endtask

   task automatic rbyte(input logic mack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_x(1'b1, s);
         d[i] = s;
      end
      bit_x(~mack, s);
   endtask
endmodule

// File: verif/rtcs_top_tb.sv
/*
 Self-checking bench for the two-wire clock/RAM slave.
 Assumes the bus master model and a pulled-up data line.
*/
`timescale 1ns/1ps
module rtcs_top_tb;
   logic core_clk, link_clk, reset, pf, upd_valid, sda_out, sda_oe, bus_active, scl, m_low;
   logic [2:0] upd_addr;
   logic [7:0] upd_data;
   wire sda_line;
   int error_cnt = 0;
   int compares = 0;

   assign sda_line = ((sda_oe && !sda_out) || m_low) ? 1'b0 : 1'b1;

   rtcs_top rtcs_top_inst (.core_clk(core_clk), .reset(reset), .link_clk(link_clk), .scl_in(scl),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .power_fail_trip_level(pf),
      .upd_valid(upd_valid), .upd_addr(upd_addr), .upd_data(upd_data), .bus_active(bus_active));

   rtcs_bus_master #(.Q(25)) rtcs_bus_master_inst (.clk(core_clk), .sda(sda_line), .scl(scl),
      .sda_low(m_low));

   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   initial
   begin
      link_clk = 1'b0;
      #7;
      forever #24 link_clk = ~link_clk;
   end

   task automatic finish_test;
      if (error_cnt == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Addressed write of n bytes, each acknowledged
   task automatic wr(input logic [7:0] a, input logic [23:0] d, input int n);
      logic k;
      rtcs_bus_master_inst.start();
      rtcs_bus_master_inst.wbyte(8'hD0, k);
      chk({7'h00, k}, 8'h01);
      rtcs_bus_master_inst.wbyte(a, k);
      chk({7'h00, k}, 8'h01);
      for (int i = 0; i < n; i++)
      begin
         rtcs_bus_master_inst.wbyte(d[23-8*i -: 8], k);
         chk({7'h00, k}, 8'h01);
      end
      rtcs_bus_master_inst.stop();
      chk({7'h00, bus_active}, 8'h00);
   endtask

   // Read of n bytes, addressed or from the stored pointer
   task automatic rd(input logic adr, input logic [7:0] a, input logic [23:0] e, input int n);
      logic k;
      logic [7:0] g;
      rtcs_bus_master_inst.start();
      if (adr)
      begin
         rtcs_bus_master_inst.wbyte(8'hD0, k);
         chk({7'h00, k}, 8'h01);
         rtcs_bus_master_inst.wbyte(a, k);
         chk({7'h00, k}, 8'h01);
         rtcs_bus_master_inst.start();
      end
      rtcs_bus_master_inst.wbyte(8'hD1, k);
      chk({7'h00, k}, 8'h01);
      for (int i = 0; i < n; i++)
      begin
         rtcs_bus_master_inst.rbyte(i < n - 1, g);
         chk(g, e[23-8*i -: 8]);
      end
      chk({7'h00, sda_oe}, 8'h00);
      rtcs_bus_master_inst.stop();
   endtask

   task automatic t_reset;
      chk({7'h00, sda_oe}, 8'h00);
      chk({7'h00, sda_out}, 8'h00);
      chk({7'h00, bus_active}, 8'h00);
   endtask

   task automatic t_wrap;
      wr(8'h3E, 24'hA5_5A_59, 3);
      rd(1'b1, 8'h3E, 24'hA5_5A_59, 3);
      rd(1'b0, 8'h00, 24'h59_00_00, 1);
   endtask

   task automatic t_bcd;
      @(negedge core_clk);
      upd_valid = 1'b1;
      upd_addr = 3'h6;
      upd_data = 8'h1C;
      @(negedge core_clk);
      upd_valid = 1'b0;
      wr(8'h07, 24'h3F_3F_00, 2);
      rd(1'b1, 8'h06, 24'h19_39_3F, 3);
   endtask

   task automatic t_addr;
      logic k;
      logic [7:0] bad [2];
      bad[0] = 8'hD2;
      bad[1] = 8'h50;
      for (int i = 0; i < 2; i++)
      begin
         rtcs_bus_master_inst.start();
         rtcs_bus_master_inst.wbyte(bad[i], k);
         chk({7'h00, k}, 8'h00);
         rtcs_bus_master_inst.stop();
      end
   endtask

   task automatic t_pf;
      logic k;
      rtcs_bus_master_inst.start();
      rtcs_bus_master_inst.wbyte(8'hD0, k);
      rtcs_bus_master_inst.wbyte(8'h20, k);
      rtcs_bus_master_inst.wbyte(8'h11, k);
      chk({7'h00, k}, 8'h01);
      for (int i = 0; i < 3; i++)
      begin
         rtcs_bus_master_inst.bit_x(1'b0, k);
      end
      chk({7'h00, bus_active}, 8'h01);
      pf = 1'b1;
      repeat (20) @(negedge core_clk);
      chk({7'h00, sda_oe}, 8'h00);
      chk({7'h00, bus_active}, 8'h00);
      rtcs_bus_master_inst.stop();
      rtcs_bus_master_inst.start();
      rtcs_bus_master_inst.wbyte(8'hD0, k);
      chk({7'h00, k}, 8'h00);
      rtcs_bus_master_inst.wbyte(8'h21, k);
      rtcs_bus_master_inst.wbyte(8'h77, k);
      rtcs_bus_master_inst.stop();
      pf = 1'b0;
      repeat (20) @(negedge core_clk);
      rd(1'b0, 8'h00, 24'h59_00_00, 1);
      rd(1'b1, 8'h20, 24'h11_00_00, 2);
   endtask

   initial
   begin
      repeat (90000) @(posedge core_clk);
      error_cnt++;
      finish_test();
   end

   initial
   begin
      reset = 1'b1;
      pf = 1'b0;
      upd_valid = 1'b0;
      upd_addr = 3'h0;
      upd_data = 8'h00;
      repeat (5) @(negedge core_clk);
      reset = 1'b0;
      repeat (10) @(negedge core_clk);
      t_reset();
      t_wrap();
      t_bcd();
      t_addr();
      t_pf();
      finish_test();
   end
endmodule
